// >>> design/dmba_regs.vh
`ifndef DMBA_REGS_VH
`define DMBA_REGS_VH
`define DMBA_IND_A_ADDR 8'h00
`define DMBA_PTR_A_ADDR 8'h01
`define DMBA_IND_B_ADDR 8'h02
`define DMBA_PTR_B_ADDR 8'h03
`define DMBA_BANK_ADDR 8'h04
`define DMBA_NVCTL_ADDR 8'h40
`define DMBA_BANK_BIT 0
`define DMBA_BANK_RST 1'h0
`define DMBA_PTR_RST 8'h00
`define DMBA_GP_START 8'h80
`endif

// >>> design/dmba_bank.v
`timescale 1ns/100ps
`default_nettype none
`include "dmba_regs.vh"
module dmba_bank #(
    parameter [7:0] GP_START = `DMBA_GP_START,
    parameter GP_WORDS = 128
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    // Watchdog reset taken while powered down
    input wire wdt_pd_reset,
    // Core access
    input wire acc_rd,
    input wire acc_wr,
    input wire [7:0] acc_addr,
    input wire [7:0] acc_wdata,
    output reg [7:0] acc_rdata,
    // Special-function area handed to other blocks
    output reg sfr_rd,
    output reg sfr_wr,
    output reg [7:0] sfr_addr,
    output reg [7:0] sfr_wdata,
    output reg sfr_bank,
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire sfr_wr_protect,
    // Bank select state
    output wire bank_sel
);
    // Architectural registers and their next values
    reg [7:0] pointer_a_r;
    reg [7:0] pointer_a_nxt;
    reg [7:0] pointer_b_r;
    reg [7:0] pointer_b_nxt;
    reg bank_select_r;
    reg bank_select_nxt;
    reg [7:0] acc_rdata_nxt;

    // General-purpose storage, one array per bank
    reg [7:0] gp0_r [0:GP_WORDS-1];
    reg [7:0] gp1_r [0:GP_WORDS-1];

    // Resolved access
    reg [7:0] eff_addr;
    reg eff_bank;
    reg eff_null;
    reg [7:0] rdata_nxt;
    wire [7:0] gp_idx;
    // Limitation: more than 128 words needs a wider word index
    wire [6:0] gp_word;
    wire eff_gp;
    wire is_ind_a;
    wire is_ind_b;

    // Per-register decode of the resolved address
    wire hit_ptr_a;
    wire hit_ptr_b;
    wire hit_bank;
    wire hit_nvctl;
    wire nvctl_hidden;
    wire sfr_area;

    // Strobes qualified by the clock enable
    wire rd_go;
    wire wr_go;
    wire we_ptr_a;
    wire we_ptr_b;
    wire we_bank;
    wire we_gp;
    // Per-word select for the general area
    wire [GP_WORDS-1:0] gp_sel;

    assign bank_sel = bank_select_r;
    assign is_ind_a = (acc_addr == `DMBA_IND_A_ADDR);
    assign is_ind_b = (acc_addr == `DMBA_IND_B_ADDR);

    // Address resolution
    always @*
    begin
        eff_addr = acc_addr;
        eff_bank = 1'b0;
        if (is_ind_a)
        begin
            eff_addr = pointer_a_r;
            eff_bank = 1'b0;
        end
        else if (is_ind_b)
        begin
            eff_addr = pointer_b_r;
            eff_bank = bank_select_r;
        end
        // A pointer aimed at either port resolves to nothing
        eff_null = (is_ind_a || is_ind_b) &&
            (eff_addr == `DMBA_IND_A_ADDR || eff_addr == `DMBA_IND_B_ADDR);
    end

    assign eff_gp = (eff_addr >= GP_START) && !eff_null;
    assign gp_idx = eff_addr - GP_START;

    // Decode of the resolved address
    assign gp_word = gp_idx[6:0];
    assign hit_ptr_a = !eff_null && (eff_addr == `DMBA_PTR_A_ADDR);
    assign hit_ptr_b = !eff_null && (eff_addr == `DMBA_PTR_B_ADDR);
    assign hit_bank = !eff_null && (eff_addr == `DMBA_BANK_ADDR);
    assign hit_nvctl = !eff_null && (eff_addr == `DMBA_NVCTL_ADDR);
    // Control register is absent from bank 0, so direct accesses never reach it
    assign nvctl_hidden = hit_nvctl && !eff_bank;
    assign sfr_area = !eff_null && !eff_gp &&
        (eff_addr > `DMBA_BANK_ADDR) && !nvctl_hidden;

    // A frozen clock enable must not let any state or strobe move
    assign rd_go = acc_rd && clk_en;
    assign wr_go = acc_wr && clk_en;
    assign we_ptr_a = wr_go && hit_ptr_a;
    assign we_ptr_b = wr_go && hit_ptr_b;
    // Watchdog reset in power-down keeps the bank, so bank writes are dropped too
    assign we_bank = wr_go && hit_bank && !wdt_pd_reset;
    assign we_gp = wr_go && eff_gp;

    // Read mux
    always @*
    begin
        rdata_nxt = 8'h00;
        if (eff_null)
        begin
            rdata_nxt = 8'h00;
        end
        else if (eff_gp)
        begin
            // Bank choice picks the array here; it also hides or shows the control register
            if (eff_bank)
            begin
                rdata_nxt = gp1_r[gp_word];
            end
            else
            begin
                rdata_nxt = gp0_r[gp_word];
            end
        end
        else if (hit_ptr_a)
        begin
            rdata_nxt = pointer_a_r;
        end
        else if (hit_ptr_b)
        begin
            rdata_nxt = pointer_b_r;
        end
        else if (hit_bank)
        begin
            rdata_nxt = {7'h00, bank_select_r};
        end
        else if (nvctl_hidden)
        begin
            rdata_nxt = 8'h00;
        end
        else if (sfr_area && sfr_hit)
        begin
            rdata_nxt = sfr_rdata;
        end
        else
        begin
            // Holes in the map must not leak the bus
            rdata_nxt = 8'h00;
        end
    end

    // Special-function forwarding: address, data and bank
    always @*
    begin
        sfr_addr = eff_addr;
        sfr_wdata = acc_wdata;
        sfr_bank = eff_bank;
    end

    // Special-function strobes
    always @*
    begin
        sfr_rd = 1'b0;
        sfr_wr = 1'b0;
        if (sfr_area)
        begin
            sfr_rd = rd_go;
            // The owning block flags protection; this side only gates the strobe
            sfr_wr = wr_go && !sfr_wr_protect;
        end
    end

    // Read data holds until the next taken read
    always @*
    begin
        acc_rdata_nxt = acc_rdata;
        if (rd_go)
        begin
            acc_rdata_nxt = rdata_nxt;
        end
    end

    // A pointer written through a port lands like a direct write
    always @*
    begin
        pointer_a_nxt = pointer_a_r;
        if (we_ptr_a)
        begin
            pointer_a_nxt = acc_wdata;
        end
    end

    always @*
    begin
        pointer_b_nxt = pointer_b_r;
        if (we_ptr_b)
        begin
            pointer_b_nxt = acc_wdata;
        end
    end

    // Only the select bit is stored; the rest reads back as zero
    always @*
    begin
        bank_select_nxt = bank_select_r;
        if (we_bank)
        begin
            bank_select_nxt = acc_wdata[`DMBA_BANK_BIT];
        end
    end

    // Read data register
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_rdata <= 8'h00;
        end
        else
        begin
            acc_rdata <= acc_rdata_nxt;
        end
    end

    // Pointer a
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pointer_a_r <= `DMBA_PTR_RST;
        end
        else
        begin
            pointer_a_r <= pointer_a_nxt;
        end
    end

    // Pointer b
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pointer_b_r <= `DMBA_PTR_RST;
        end
        else
        begin
            pointer_b_r <= pointer_b_nxt;
        end
    end

    // Watchdog reset in power-down keeps the bank, so it is a separate input
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bank_select_r <= `DMBA_BANK_RST;
        end
        else
        begin
            bank_select_r <= bank_select_nxt;
        end
    end

    // General-purpose storage, no reset: undefined until written
    genvar i;
    generate
        for (i = 0; i < GP_WORDS; i = i + 1)
        begin : g_gp
            assign gp_sel[i] = (gp_idx == i);
            // One enable per word keeps each entry single-driven
            always @(posedge sys_clk)
            begin
                if (we_gp && gp_sel[i])
                begin
                    if (eff_bank)
                    begin
                        gp1_r[i] <= acc_wdata;
                    end
                    else
                    begin
                        gp0_r[i] <= acc_wdata;
                    end
                end
            end
        end
    endgenerate
endmodule // dmba_bank
`default_nettype wire

// >>> verification/dmba_bank_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dmba_bank_checker #(parameter logic [7:0] GP_START = 8'h80) (
    // Clock, reset, controls
    input wire logic sys_clk, rst, clk_en, wdt_pd_reset, acc_rd, acc_wr,
    // Strobes and bank
    input wire logic sfr_rd, sfr_wr, sfr_bank, sfr_hit, sfr_wr_protect, bank_sel,
    // Buses
    input wire logic [7:0] acc_addr, acc_wdata, acc_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_pd_hold: assert property (wdt_pd_reset |=> $stable(bank_sel)) else $error("bank moved");
    chk_bank_wr: assert property (clk_en && acc_wr && acc_addr == 8'h04 && !wdt_pd_reset
        |=> bank_sel == $past(acc_wdata[0])) else $error("bank write lost");
    chk_bank_rd: assert property (clk_en && acc_rd && !acc_wr && acc_addr == 8'h04
        |=> acc_rdata == {7'h00, $past(bank_sel)}) else $error("bank read");
    chk_unused_rd: assert property (clk_en && acc_rd && acc_addr > 8'h04 && acc_addr < GP_START
        && !sfr_hit |=> acc_rdata == 8'h00) else $error("unused not zero");
    chk_direct_b0: assert property (sfr_rd && acc_addr > 8'h04 |-> !sfr_bank) else $error("direct bank");
    chk_port_a_b0: assert property (sfr_rd && acc_addr == 8'h00 |-> !sfr_bank) else $error("port a bank");
    chk_port_b_bank: assert property (sfr_rd && acc_addr == 8'h02
        |-> sfr_bank == bank_sel) else $error("b bank");
    chk_protect_wr: assert property (sfr_wr_protect |-> !sfr_wr) else $error("protected write");
    chk_gp_local: assert property (acc_addr >= GP_START |-> !sfr_rd && !sfr_wr) else $error("gp strobe");
endmodule // dmba_bank_checker
bind dmba_bank dmba_bank_checker #(.GP_START(GP_START)) i_chk(.sys_clk, .rst, .clk_en, .wdt_pd_reset,
    .acc_rd, .acc_wr, .sfr_rd, .sfr_wr, .sfr_bank, .sfr_hit, .sfr_wr_protect, .bank_sel, .acc_addr,
    .acc_wdata, .acc_rdata);
`default_nettype wire

// >>> verification/dmba_sfr_model.sv
`timescale 1ns/100ps
`default_nettype none
module dmba_sfr_model (
    input wire logic sys_clk, sfr_wr, sfr_bank,
    input wire logic [7:0] sfr_addr, sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit, sfr_wr_protect
);
    logic [7:0] m [128];
    assign sfr_hit = (sfr_addr > 8'h04 && sfr_addr < 8'h40) || (sfr_addr == 8'h40 && sfr_bank);
    assign sfr_wr_protect = sfr_addr == 8'h08;
    // Garbage when not hit, so a decoder that trusts it shows up
    assign sfr_rdata = sfr_wr_protect ? 8'hC3 : sfr_hit ? m[sfr_addr[6:0]] : 8'h5A;
    always @(posedge sys_clk) if (sfr_wr && sfr_hit) m[sfr_addr[6:0]] <= sfr_wdata;
endmodule // dmba_sfr_model
`default_nettype wire

// >>> verification/data_memory_bank_addressing_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module data_memory_bank_addressing_tb_top;
    logic sys_clk = 0, rst = 1, clk_en = 1, wdt_pd_reset = 0, acc_rd = 0, acc_wr = 0;
    logic sfr_rd, sfr_wr, sfr_bank, sfr_hit, sfr_wr_protect, bank_sel;
    logic [7:0] acc_addr = 0, acc_wdata = 0, acc_rdata, sfr_addr, sfr_wdata, sfr_rdata;
    int errors = 0, n_compared = 0, cyc = 0;
    dmba_bank i_dut(.sys_clk, .rst, .clk_en, .wdt_pd_reset, .acc_rd, .acc_wr, .acc_addr, .acc_wdata, .acc_rdata,
        .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_bank, .sfr_rdata, .sfr_hit, .sfr_wr_protect, .bank_sel);
    dmba_sfr_model i_sfr(.sys_clk, .sfr_wr, .sfr_bank, .sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit, .sfr_wr_protect);
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (++cyc > 2000) begin errors++; conclude(); end
    task conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Request held over exactly one taking edge
    task acc(input logic w, input logic [7:0] a, d);
        @(posedge sys_clk); {acc_wr, acc_rd, acc_addr, acc_wdata} <= {w, !w, a, d};
        @(posedge sys_clk); {acc_wr, acc_rd} <= 2'h0;
    endtask
    task wr(input logic [7:0] a, d); acc(1, a, d); endtask
    task rd(input logic [7:0] a, e);
        acc(0, a, 8'h00); #1 n_compared++;
        if (acc_rdata !== e) begin errors++; $display("CHECK FAILED rdata@%h exp %h got %h", a, e, acc_rdata); end
    endtask
    task t_reset; rd(8'h04, 8'h00); rd(8'h01, 8'h00); $display("t_reset done"); endtask
    task t_indirect;
        wr(8'h01, 8'h85); wr(8'h00, 8'h11); rd(8'h85, 8'h11);
        wr(8'h03, 8'h85); wr(8'h04, 8'hFF); rd(8'h04, 8'h01);
        wr(8'h02, 8'h22); rd(8'h85, 8'h11); rd(8'h00, 8'h11); rd(8'h02, 8'h22);
        wr(8'h04, 8'h00); rd(8'h02, 8'h11); rd(8'h03, 8'h85);
        $display("t_indirect done");
    endtask
    task t_sfr;
        wr(8'h20, 8'h77); rd(8'h20, 8'h77); wr(8'h08, 8'h12); rd(8'h08, 8'hC3);
        rd(8'h50, 8'h00); wr(8'h40, 8'h99); rd(8'h40, 8'h00);
        wr(8'h03, 8'h40); wr(8'h04, 8'h01); wr(8'h02, 8'h99); rd(8'h02, 8'h99);
        $display("t_sfr done");
    endtask
    task t_port;
        wr(8'h01, 8'h02); rd(8'h00, 8'h00); wr(8'h00, 8'h33); rd(8'h02, 8'h99);
        wr(8'h01, 8'h20); rd(8'h00, 8'h77); $display("t_port done");
    endtask
    task t_hold;
        @(posedge sys_clk) clk_en <= 0;
        rd(8'h01, 8'h77); wr(8'h01, 8'h5A);
        @(posedge sys_clk) clk_en <= 1;
        rd(8'h01, 8'h20); $display("t_hold done");
    endtask
    task t_wdt;
        @(posedge sys_clk) wdt_pd_reset <= 1;
        wr(8'h04, 8'h00); rd(8'h04, 8'h01);
        @(posedge sys_clk) {wdt_pd_reset, rst} <= 2'h1;
        @(posedge sys_clk) rst <= 0;
        rd(8'h04, 8'h00); $display("t_wdt done");
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 0;
        t_reset();
        t_indirect();
        t_sfr();
        t_port();
        t_hold();
        t_wdt();
        conclude();
    end
endmodule // data_memory_bank_addressing_tb_top
`default_nettype wire
